// ===== drive_host_model.sv
// Host management model that issues power commands on both management sides.
`timescale 1ns/1ps
module drive_host_model
   import drive_pwr_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Command outputs
   output drive_pwr_pkg::pwr_cmd_t i2c_cmd_o,
   output drive_pwr_pkg::pwr_cmd_t bus_cmd_o
);
   import drive_pwr_pkg::*;
   initial begin
      i2c_cmd_o = '0;
      bus_cmd_o = '0;
   end
   // Called just after an edge; the pulse lasts exactly one cycle.
   task automatic send(input logic use_bus, input logic on, input logic drv);
      pwr_cmd_t c;
      c = '{valid: 1'b1, on: on, drive: drv};
      if (use_bus) bus_cmd_o = c;
      else i2c_cmd_o = c;
      @(posedge clk_i);
      #1;
      // Clear only the side used, so a following call on the other side is not overwritten.
      if (use_bus) bus_cmd_o = '0;
      else i2c_cmd_o = '0;
   endtask
endmodule

// ===== drive_hotplug_power_ctrl.sv
// Two-drive hot-plug power controller with rail retry, stagger and status LEDs.
// Operation
// R1: Report drive detection to the host; never power a drive unprompted.
// R2: Host sends an explicit power-on command after presence is reported.
// R3: A depower command switches off both rails of that drive.
// R4: After reinsertion the host must command power-on again.
// R5: Separate 12 V and 5 V switch enables per drive.
// R6: Over-current on a rail turns off only that rail.
// R7: Tripped rail retries every third of a second until clear or depowered.
// R8: Over-current is ignored for 640 ns after each switch enable.
// R9: Drive start-ups are serialised by an interlock.
// R10: A waiting drive starts a third of a second after the previous one.
// R11: One bi-colour indicator per drive, colour plus blink.
// R12: Blink green is activity, yellow blink is fault, solid green or dark neither.
// R13: Drive status is offered to both management sides.
// R14: Commands are accepted from the drive bus side and the I2C side.
// R15: LEDs and rail switches are driven as plain controller outputs.
// R16: Boot block in top of program store is write protected.
// R17: I2C management stays isolated until system power good.
// R18: Presence comes from each connector interlock input.
// R19: All timing derives from one clock.
// R20: Blink periods are parameters.
`timescale 1ns/1ps
module drive_hotplug_power_ctrl
   import drive_pwr_pkg::*;
#(
   parameter int RETRY_CNT = RETRY_CYCLES,
   parameter int BLINK_CNT = BLINK_CYCLES
) (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // Drive connector side
   input wire logic [NUM_DRIVES-1:0] INTERLOCK_I,
   input wire logic [NUM_DRIVES-1:0] OC12_I,
   input wire logic [NUM_DRIVES-1:0] OC5_I,
   input wire logic [NUM_DRIVES-1:0] ACTIVITY_I,
   output logic [NUM_DRIVES-1:0] EN12_O,
   output logic [NUM_DRIVES-1:0] EN5_O,
   output logic [NUM_DRIVES-1:0] LED_GREEN_O,
   output logic [NUM_DRIVES-1:0] LED_YELLOW_O,
   // Management commands
   input wire logic SYSTEM_POWER_GOOD_I,
   input wire drive_pwr_pkg::pwr_cmd_t I2C_CMD_I,
   input wire drive_pwr_pkg::pwr_cmd_t BUS_CMD_I,
   // Status to management
   output drive_pwr_pkg::drive_status_t [NUM_DRIVES-1:0] I2C_STATUS_O,
   output drive_pwr_pkg::drive_status_t [NUM_DRIVES-1:0] BUS_STATUS_O,
   output logic I2C_LINK_EN_O,
   output logic [NUM_DRIVES-1:0] PRESENT_EVT_O,
   // Program store write guard
   input wire logic FLASH_WR_REQ_I,
   input wire logic [FLASH_ADDR_W-1:0] FLASH_WR_ADDR_I,
   output logic FLASH_WR_EN_O
);
   import drive_pwr_pkg::*;

   logic [NUM_DRIVES-1:0] il_meta_reg, il_sync_reg, il_prev_reg;
   logic [NUM_DRIVES-1:0] oc12_meta_reg, oc12_sync_reg, oc5_meta_reg, oc5_sync_reg;
   logic [NUM_DRIVES-1:0] act_meta_reg, act_sync_reg;
   logic pg_meta_reg, pg_sync_reg;
   logic [NUM_DRIVES-1:0] on_cmd_reg, on_cmd_next;
   logic [NUM_DRIVES-1:0] started_reg, started_next;
   logic [NUM_DRIVES-1:0] trip12_reg, trip5_reg;
   logic [NUM_DRIVES-1:0] en12_reg, en5_reg;
   logic [BLANK_W-1:0] blank12_reg [NUM_DRIVES];
   logic [BLANK_W-1:0] blank5_reg [NUM_DRIVES];
   logic [TMR_W-1:0] retry12_reg [NUM_DRIVES];
   logic [TMR_W-1:0] retry5_reg [NUM_DRIVES];
   logic [TMR_W-1:0] stagger_reg;
   logic [TMR_W-1:0] blink_reg;
   logic blink_ph_reg;
   logic [NUM_DRIVES-1:0] led_g_reg, led_y_reg;

   function automatic logic timer_done(input logic [TMR_W-1:0] t, input int lim);
      timer_done = (t >= TMR_W'(lim - 1));
   endfunction

   // Either management side may issue a command; I2C is ignored until power good.
   wire i2c_ok = pg_sync_reg; // R17
   wire pwr_cmd_t cmd = (I2C_CMD_I.valid && i2c_ok) ? I2C_CMD_I : BUS_CMD_I; // R14
   wire stagger_busy = !timer_done(stagger_reg, RETRY_CNT);
   wire [NUM_DRIVES-1:0] present = il_sync_reg; // R18
   // Lowest-numbered waiting drive wins the interlock.
   wire [NUM_DRIVES-1:0] waiting = on_cmd_reg & ~started_reg & present;
   wire [NUM_DRIVES-1:0] grant = stagger_busy ? '0 : (waiting & (~waiting + 1'b1)); // R9 R10

   always_comb begin
      on_cmd_next = on_cmd_reg;
      started_next = started_reg;
      if (cmd.valid) begin
         on_cmd_next[cmd.drive] = cmd.on; // R1 R2 R3
      end
      for (int d = 0; d < NUM_DRIVES; d++) begin
         if (!present[d]) begin
            on_cmd_next[d] = 1'b0; // R4
         end
         if (!on_cmd_next[d]) begin
            started_next[d] = 1'b0;
         end else if (grant[d]) begin
            started_next[d] = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         il_meta_reg <= '0;
         il_sync_reg <= '0;
         il_prev_reg <= '0;
         oc12_meta_reg <= '0;
         oc12_sync_reg <= '0;
         oc5_meta_reg <= '0;
         oc5_sync_reg <= '0;
         act_meta_reg <= '0;
         act_sync_reg <= '0;
         pg_meta_reg <= 1'b0;
         pg_sync_reg <= 1'b0;
      end else begin
         il_meta_reg <= INTERLOCK_I;
         il_sync_reg <= il_meta_reg;
         il_prev_reg <= il_sync_reg;
         oc12_meta_reg <= OC12_I;
         oc12_sync_reg <= oc12_meta_reg;
         oc5_meta_reg <= OC5_I;
         oc5_sync_reg <= oc5_meta_reg;
         act_meta_reg <= ACTIVITY_I;
         act_sync_reg <= act_meta_reg;
         pg_meta_reg <= SYSTEM_POWER_GOOD_I;
         pg_sync_reg <= pg_meta_reg;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         on_cmd_reg <= '0;
         started_reg <= '0;
         stagger_reg <= '1;
      end else begin
         on_cmd_reg <= on_cmd_next;
         started_reg <= started_next;
         if (|grant) begin
            stagger_reg <= '0; // R10
         end else if (stagger_busy) begin
            stagger_reg <= stagger_reg + 1'b1;
         end
      end
   end

   // Per-rail trip, blanking and retry; both rails share one pattern.
   for (genvar d = 0; d < NUM_DRIVES; d++) begin : g_rail
      wire want = started_reg[d];
      wire blank12_done = (blank12_reg[d] == BLANK_LAST);
      wire blank5_done = (blank5_reg[d] == BLANK_LAST);
      wire trip12_now = en12_reg[d] && blank12_done && oc12_sync_reg[d]; // R6 R8
      wire trip5_now = en5_reg[d] && blank5_done && oc5_sync_reg[d]; // R6 R8
      wire retry12_go = trip12_reg[d] && timer_done(retry12_reg[d], RETRY_CNT); // R7
      wire retry5_go = trip5_reg[d] && timer_done(retry5_reg[d], RETRY_CNT); // R7

      always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
         if (RST_I) begin
            en12_reg[d] <= 1'b0;
            en5_reg[d] <= 1'b0;
            trip12_reg[d] <= 1'b0;
            trip5_reg[d] <= 1'b0;
            blank12_reg[d] <= '0;
            blank5_reg[d] <= '0;
            retry12_reg[d] <= '0;
            retry5_reg[d] <= '0;
         end else begin
            // Blanking restarts on every fresh enable, including retries.
            blank12_reg[d] <= (!en12_reg[d]) ? '0 :
               (blank12_done ? blank12_reg[d] : blank12_reg[d] + 1'b1); // R8
            blank5_reg[d] <= (!en5_reg[d]) ? '0 :
               (blank5_done ? blank5_reg[d] : blank5_reg[d] + 1'b1); // R8
            retry12_reg[d] <= trip12_reg[d] ? retry12_reg[d] + 1'b1 : '0;
            retry5_reg[d] <= trip5_reg[d] ? retry5_reg[d] + 1'b1 : '0;
            if (!want) begin
               en12_reg[d] <= 1'b0; // R3
               en5_reg[d] <= 1'b0; // R3
               trip12_reg[d] <= 1'b0;
               trip5_reg[d] <= 1'b0;
            end else begin
               en12_reg[d] <= !trip12_now && (en12_reg[d] || !trip12_reg[d] || retry12_go); // R5
               en5_reg[d] <= !trip5_now && (en5_reg[d] || !trip5_reg[d] || retry5_go); // R5
               trip12_reg[d] <= trip12_now || (trip12_reg[d] && !retry12_go); // R7
               trip5_reg[d] <= trip5_now || (trip5_reg[d] && !retry5_go); // R7
            end
         end
      end
   end

   // The blink period has its own parameter, BLINK_CNT; a shared divider keeps LEDs in step.
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         blink_reg <= '0;
         blink_ph_reg <= 1'b0;
      end else if (timer_done(blink_reg, BLINK_CNT)) begin
         blink_reg <= '0; // R20
         blink_ph_reg <= ~blink_ph_reg;
      end else begin
         blink_reg <= blink_reg + 1'b1;
      end
   end

   wire [NUM_DRIVES-1:0] fault = trip12_reg | trip5_reg;
   wire [NUM_DRIVES-1:0] powered = en12_reg & en5_reg;
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         led_g_reg <= '0;
         led_y_reg <= '0;
      end else begin
         for (int d = 0; d < NUM_DRIVES; d++) begin
            // Fault blinks yellow against green when present, else against dark.
            led_y_reg[d] <= fault[d] && blink_ph_reg; // R11 R12
            led_g_reg[d] <= fault[d] ? (present[d] && !blink_ph_reg) :
               (powered[d] && (!act_sync_reg[d] || blink_ph_reg)); // R12
         end
      end
   end

   always_comb begin
      for (int d = 0; d < NUM_DRIVES; d++) begin
         I2C_STATUS_O[d] = '{present[d], on_cmd_reg[d], en12_reg[d], en5_reg[d],
            trip12_reg[d], trip5_reg[d]}; // R13
      end
   end

   assign BUS_STATUS_O = I2C_STATUS_O; // R13
   assign PRESENT_EVT_O = il_sync_reg & ~il_prev_reg; // R1
   assign I2C_LINK_EN_O = pg_sync_reg; // R17
   assign EN12_O = en12_reg; // R15
   assign EN5_O = en5_reg; // R15
   assign LED_GREEN_O = led_g_reg; // R15
   assign LED_YELLOW_O = led_y_reg; // R15
   // Updates arrive only over the I2C link and never reach the boot block.
   assign FLASH_WR_EN_O = FLASH_WR_REQ_I && i2c_ok &&
      (FLASH_WR_ADDR_I < BOOT_BLOCK_BASE); // R16

   // Independent count of cycles since the last start, kept apart from the stagger timer.
   // It saturates, so the very first start after reset is always allowed.
   logic [TMR_W-1:0] since_start_reg;
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         since_start_reg <= '1;
      end else if (|grant) begin
         since_start_reg <= '0;
      end else if (since_start_reg != '1) begin
         since_start_reg <= since_start_reg + 1'b1;
      end
   end

   // A depower may land on the very edge that raises the rail, so look back to the grant.
   a_no_self_power: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      $rose(en12_reg[0]) |-> $past(on_cmd_reg[0], 2)) else $error("drive powered unprompted"); // R1
   a_depower_both: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      !on_cmd_reg[0] |=> ##1 !EN12_O[0] && !EN5_O[0]) else $error("rails stayed on"); // R3
   a_trip_one_rail: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      en12_reg[0] && blank12_reg[0] == BLANK_LAST && oc12_sync_reg[0] && !oc5_sync_reg[0]
      && en5_reg[0] && started_reg[0] && on_cmd_next[0] |=> !en12_reg[0] && en5_reg[0])
      else $error("wrong rail tripped"); // R6
   a_blank_ignore: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      $rose(en5_reg[1]) |-> !trip5_reg[1] [*8]) else $error("trip in blanking"); // R8
   a_single_start: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      $onehot0(grant)) else $error("two drives started"); // R9
   a_stagger_gap: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      |grant |=> !(|grant) [*8]) else $error("start too soon"); // R10
   a_led_fault: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      led_y_reg[0] |-> $past(fault[0])) else $error("yellow without fault"); // R12
   a_i2c_isolated: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      !pg_sync_reg |-> !I2C_LINK_EN_O && !FLASH_WR_EN_O) else $error("link not isolated"); // R17
   a_stagger_span: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      |grant |-> since_start_reg >= TMR_W'(RETRY_CNT - 1)) else $error("stagger too short"); // R10
   a_retry_release: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      $rose(en12_reg[0]) && $past(trip12_reg[0]) |-> $past(retry12_reg[0]) >= TMR_W'(RETRY_CNT - 1))
      else $error("retry came early"); // R7
   a_trip_rail5: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      en5_reg[1] && blank5_reg[1] == BLANK_LAST && oc5_sync_reg[1] |=> !en5_reg[1])
      else $error("rail5 not tripped"); // R6
   a_removal_clears: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      !present[1] |=> !on_cmd_reg[1]) else $error("command kept after removal"); // R4
   a_depower_drive1: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      !on_cmd_reg[1] |=> ##1 !EN12_O[1] && !EN5_O[1]) else $error("drive1 rails stayed on"); // R3
   a_led_dark: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      !fault[0] && !powered[0] |=> !led_g_reg[0] && !led_y_reg[0]) else $error("LED lit idle"); // R12
   a_present_pulse: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      PRESENT_EVT_O[0] |=> !PRESENT_EVT_O[0]) else $error("presence event too long"); // R1
   a_flash_guard: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
      FLASH_WR_EN_O |-> FLASH_WR_ADDR_I < BOOT_BLOCK_BASE) else $error("boot block written"); // R16
   c_power_on: cover property (@(posedge CLK_SYS_I) disable iff (RST_I) $rose(EN12_O[0]));
   c_trip: cover property (@(posedge CLK_SYS_I) disable iff (RST_I) $rose(trip5_reg[1]));
   c_both_wait: cover property (@(posedge CLK_SYS_I) disable iff (RST_I) &waiting);
   c_retry: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
      $rose(EN12_O[0]) && $past(trip12_reg[0]));
   c_depower: cover property (@(posedge CLK_SYS_I) disable iff (RST_I) $fell(EN5_O[0]));
endmodule

// ===== drive_hotplug_power_ctrl_tb_top.sv
// Self-checking testbench for the drive hot-plug power controller.
`timescale 1ns/1ps
module drive_hotplug_power_ctrl_tb_top;
   import drive_pwr_pkg::*;
   // Short counts keep the run brief; expectations follow them.
   localparam int RETRY = 200;
   localparam int BLINK = 50;
   logic clk, rst, pg, link_en, wr_req, wr_en;
   logic [1:0] lock, oc12, oc5, act, en12, en5, led_g, led_y, evt;
   logic [3:0] ens;
   logic [FLASH_ADDR_W-1:0] wr_addr;
   pwr_cmd_t i2c_cmd, bus_cmd;
   drive_status_t [1:0] i2c_st, bus_st;
   int bad_count, samples_checked, n, ny, ng;
   assign ens = {en5, en12};
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   drive_hotplug_power_ctrl #(.RETRY_CNT(RETRY), .BLINK_CNT(BLINK)) drive_hotplug_power_ctrl_i (
      .CLK_SYS_I(clk), .RST_I(rst), .INTERLOCK_I(lock), .OC12_I(oc12), .OC5_I(oc5),
      .ACTIVITY_I(act), .EN12_O(en12), .EN5_O(en5), .LED_GREEN_O(led_g),
      .LED_YELLOW_O(led_y), .SYSTEM_POWER_GOOD_I(pg), .I2C_CMD_I(i2c_cmd),
      .BUS_CMD_I(bus_cmd), .I2C_STATUS_O(i2c_st), .BUS_STATUS_O(bus_st),
      .I2C_LINK_EN_O(link_en), .PRESENT_EVT_O(evt), .FLASH_WR_REQ_I(wr_req),
      .FLASH_WR_ADDR_I(wr_addr), .FLASH_WR_EN_O(wr_en));
   drive_host_model drive_host_model_i (.clk_i(clk), .i2c_cmd_o(i2c_cmd), .bus_cmd_o(bus_cmd));
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Cycles that one enable stays at a level, bounded so a hang cannot occur.
   task automatic run_len(input int sel, input logic lvl, output int len);
      len = 0;
      while (ens[sel] === lvl && len < 1000) begin
         step(1);
         len++;
      end
   endtask
   task automatic complete_run();
      if (bad_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic t_detect();
      lock = 2'b01;
      n = 0;
      repeat (8) begin
         step(1);
         if (evt[0] === 1'b1) n++;
      end
      chk(n, 1);
      drive_host_model_i.send(0, 1, 0);
      step(10);
      chk({en12, en5}, 0);
      chk(link_en, 0);
      chk(i2c_st[0], 6'b10_0000);
      chk(bus_st[0], 6'b10_0000);
   endtask
   task automatic t_stagger();
      pg = 1;
      step(4);
      chk(link_en, 1);
      lock = 2'b11;
      step(4);
      drive_host_model_i.send(0, 1, 0);
      drive_host_model_i.send(1, 1, 1);
      run_len(0, 0, n);
      chk(n <= 4, 1);
      run_len(1, 0, n);
      chk(n >= RETRY - 4 && n <= RETRY + 4, 1);
      step(2);
      chk({en12, en5}, 4'hF);
      chk(i2c_st[1], 6'b11_1100);
   endtask
   task automatic t_trip();
      oc12[0] = 1;
      act = 2'b10;
      run_len(0, 1, n);
      chk(n <= 6, 1);
      chk(en5[0], 1);
      ny = 0;
      ng = 0;
      repeat (2 * BLINK + 10) begin
         step(1);
         ny += (led_y[0] === 1'b1);
         ng += (led_g[1] === 1'b1);
      end
      chk(ny > 0 && ny < 2 * BLINK + 10, 1);
      chk(ng > 0 && ng < 2 * BLINK + 10, 1);
      chk(led_y[1], 0);
      run_len(0, 0, n);
      chk(n >= RETRY - 2 * BLINK - 20 && n <= RETRY - 2 * BLINK - 4, 1);
      run_len(0, 1, n);
      chk(n >= BLANK_CYCLES && n <= BLANK_CYCLES + 6, 1);
      oc12[0] = 0;
      run_len(0, 0, n);
      chk(n >= RETRY - 6 && n <= RETRY + 6, 1);
      step(300);
      chk(en12[0], 1);
   endtask
   task automatic t_off();
      drive_host_model_i.send(0, 0, 0);
      step(4);
      chk({en12[0], en5[0]}, 0);
      lock[1] = 0;
      step(8);
      chk({en12[1], en5[1]}, 0);
      lock[1] = 1;
      step(RETRY + 20);
      chk({en12[1], en5[1], i2c_st[1].on_cmd}, 0);
      wr_req = 1;
      wr_addr = 19'h7_0000;
      #1 chk(wr_en, 0);
      wr_addr = 19'h6_FFFF;
      #1 chk(wr_en, 1);
      wr_req = 0;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      complete_run();
   end
   initial begin
      {rst, pg, wr_req, lock, oc12, oc5, act, wr_addr} = '0;
      rst = 1;
      step(3);
      rst = 0;
      step(2);
      t_detect();
      t_stagger();
      t_trip();
      t_off();
      complete_run();
   end
endmodule

// ===== drive_pwr_pkg.sv
// Shared constants and types for the drive hot-plug power controller.
package drive_pwr_pkg;
   localparam int NUM_DRIVES = 2;
   localparam int CLK_MHZ = 200;
   localparam int BOARD_CLK_MHZ = 10;
   // Retry and stagger periods are one third of a second.
   localparam int RETRY_PERIOD_US = 333333;
   localparam int RETRY_CYCLES = RETRY_PERIOD_US * CLK_MHZ;
   // Over-current blanking after each switch enable.
   localparam int BLANK_NS = 640;
   localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
   localparam int BLANK_CYCLES = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W = 27;
   localparam int BLANK_W = 8;
   localparam logic [BLANK_W-1:0] BLANK_LAST = BLANK_W'(BLANK_CYCLES - 1);
   localparam int BLINK_CYCLES = 40000000;
   localparam int FLASH_ADDR_W = 19;
   localparam logic [FLASH_ADDR_W-1:0] BOOT_BLOCK_BASE = 19'h7_0000;

   typedef enum logic [1:0] {
      LED_DARK,
      LED_GREEN,
      LED_YELLOW
   } led_color_t;

   // One power command from either management side.
   typedef struct packed {
      logic valid;
      logic on;
      logic drive;
   } pwr_cmd_t;

   // Status word gathered per drive.
   typedef struct packed {
      logic present;
      logic on_cmd;
      logic rail12_on;
      logic rail5_on;
      logic fault12;
      logic fault5;
   } drive_status_t;
endpackage
